// >>> sio_host.sv
// processor end: runs frames on the serial bus and returns load results
// assumes one command at a time from a local sequencer on sys_clk
//
// How it works
// - five lines: two data, clock, reset, attention
// - up to 16 drops decode own address
// - processor drives clock, reset, data; receives attention
// - first pair is the operation code
// - pairs two to five carry address, msb first
// - peripherals shift header on trailing clock edge
// - unmatched peripherals count clocks then idle
// - addressed peripheral captures store data pairs
// - store data split across lines as defined
// - load data sent msb pairs, line a higher
// - processor releases data lines on sixth pulse
// - sample on seventh trailing edge, peripheral advances
// - three or seven more pulses, then peripheral resets
// - poll is word load with reserved address
// - first received poll bit wins priority
// - reset line clears all peripherals
// - bus clock 200 ns period, 100 ns high
`timescale 1ns/10ps
`default_nettype none

module sio_host #(
   parameter int RESET_CYCLES = sio_pkg::RESET_CYC
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // command port
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [1:0]  cmd_op,
   input  wire logic        cmd_poll,
   input  wire logic [7:0]  cmd_addr,
   input  wire logic [15:0] cmd_data,
   // answer port
   output logic             rsp_valid,
   input  wire logic        rsp_ready,
   output logic [15:0]      rsp_data,
   output logic             rsp_poll,
   output logic             rsp_found,
   output logic [3:0]       rsp_index,
   // system
   input  wire logic        reset_request,
   output logic             attention,
   // bus
   sio_if.host              bus
);
   localparam logic [5:0] PERIOD_LAST = 6'(sio_pkg::BIT_PERIOD_CYC - 1);
   localparam logic [5:0] HIGH_LAST   = 6'(sio_pkg::PULSE_HIGH_CYC - 1);
   localparam logic [7:0] RESET_LAST  = 8'(RESET_CYCLES - 1);

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_IDLE  = 2'b01,
      ST_PULSE = 2'b10
   } host_state_t;

   typedef struct packed {
      logic        poll;
      logic        found;
      logic [3:0]  idx;
      logic [15:0] data;
   } rsp_t;

   typedef struct packed {
      host_state_t st;
      logic [5:0]  ph;        // phase inside one bit period
      logic [3:0]  pulse;     // pulse number, 1 based
      logic [7:0]  rcnt;
      logic [1:0]  op;
      logic        poll;
      logic [12:0] sh_a, sh_b;
      logic [15:0] rx;
      logic        clk_o, rst_o, a_o, b_o, oe;
      logic [1:0]  sa, sb, sn;   // synchronisers
      logic        cmd_ready;
      logic        attention;
      logic        v0, v1;       // two-entry answer buffer
      rsp_t        e0, e1;
   } host_reg_t;

   host_reg_t   r, n;
   logic        push, pop;
   rsp_t        res;
   logic [7:0]  addr;
   logic [1:0]  op;

   // highest set bit, which is also the first to arrive on a poll
   function automatic logic [3:0] first_bit(input logic [15:0] v);
      first_bit = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) first_bit = 4'(i);
      end
   endfunction

   // =========================================================
   // frame sequencer, clock divider and answer buffer
   always_comb begin
      n = r;
      n.sa = {r.sa[0], bus.serial_line_a};
      n.sb = {r.sb[0], bus.serial_line_b};
      n.sn = {r.sn[0], bus.serial_attention_request};
      n.attention = r.sn[1];
      push = 1'b0;
      pop = r.v0 & rsp_ready;
      op = cmd_poll ? sio_pkg::OP_LOAD_WORD : cmd_op;
      addr = cmd_poll ? {sio_pkg::POLL_NIBBLE, cmd_addr[3:0]} : cmd_addr;
      res = '0;
      res.poll = r.poll;
      res.data = sio_pkg::is_word(r.op) ? r.rx : {8'h00, r.rx[7:0]};
      res.found = r.poll & (|r.rx);
      res.idx = first_bit(r.rx);
      if (reset_request && r.st != ST_RESET) begin
         // operator panel or reset instruction: abort and reset
         n.st = ST_RESET;
         n.rcnt = '0;
         n.rst_o = 1'b1;
         n.clk_o = 1'b0;
         n.oe = 1'b0;
      end else begin
         unique case (r.st)
            ST_RESET: begin
               n.rst_o = 1'b1;
               if (r.rcnt == RESET_LAST) begin
                  n.st = ST_IDLE;
                  n.rst_o = 1'b0;
               end else begin
                  n.rcnt = r.rcnt + 8'h01;
               end
            end
            ST_IDLE: begin
               if (cmd_valid && r.cmd_ready) begin
                  n.st = ST_PULSE;
                  n.op = op;
                  n.poll = cmd_poll;
                  n.ph = '0;
                  n.pulse = 4'h1;
                  n.rx = '0;
                  n.sh_a = {op[1], addr[7:4],
                            sio_pkg::is_word(op) ? cmd_data[7:0]
                                      : {cmd_data[7:4], 4'h0}};
                  n.sh_b = {op[0], addr[3:0],
                            sio_pkg::is_word(op) ? cmd_data[15:8]
                                      : {cmd_data[3:0], 4'h0}};
                  n.a_o = op[1];
                  n.b_o = op[0];
                  n.oe = 1'b1;
                  n.clk_o = 1'b1;
               end
            end
            ST_PULSE: begin
               n.ph = r.ph + 6'h01;
               if (r.ph == HIGH_LAST) begin
                  n.clk_o = 1'b0;
                  if (sio_pkg::is_load(r.op) &&
                      r.pulse >= sio_pkg::FIRST_RX) begin
                     n.rx = {r.rx[13:0], r.sa[1], r.sb[1]};
                  end
               end
               if (r.ph == PERIOD_LAST) begin
                  if (r.pulse == sio_pkg::frame_pulses(r.op)) begin
                     n.st = ST_IDLE;
                     n.oe = 1'b0;
                     push = sio_pkg::is_load(r.op);
                  end else begin
                     n.ph = '0;
                     n.pulse = r.pulse + 4'h1;
                     n.clk_o = 1'b1;
                     n.sh_a = {r.sh_a[11:0], 1'b0};
                     n.sh_b = {r.sh_b[11:0], 1'b0};
                     n.a_o = r.sh_a[11];
                     n.b_o = r.sh_b[11];
                     // a load hands the lines over from pulse six on
                     n.oe = !(sio_pkg::is_load(r.op) &&
                              n.pulse >= sio_pkg::TURN_PULSE);
                  end
               end
            end
            default: n.st = ST_RESET;
         endcase
      end
      // buffer: pop first, then push into the first free slot
      if (pop) begin
         n.v0 = r.v1;
         n.e0 = r.e1;
         n.v1 = 1'b0;
      end
      if (push) begin
         if (!n.v0) begin
            n.v0 = 1'b1;
            n.e0 = res;
         end else begin
            n.v1 = 1'b1;
            n.e1 = res;
         end
      end
      // take a command only with a slot free, so no answer is lost
      n.cmd_ready = (n.st == ST_IDLE) && !n.v1 && !reset_request;
   end

   // =========================================================
   // single state register, bus reset held from power-up
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
         r.st <= ST_RESET;
         r.rst_o <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // =========================================================
   // outputs, all straight from the state register
   assign bus.serial_bit_clock = r.clk_o;
   assign bus.serial_bus_reset = r.rst_o;
   assign bus.host_a_o = r.a_o;
   assign bus.host_b_o = r.b_o;
   assign bus.host_a_oe = r.oe;
   assign bus.host_b_oe = r.oe;
   assign cmd_ready = r.cmd_ready;
   assign rsp_valid = r.v0;
   assign rsp_data = r.e0.data;
   assign rsp_poll = r.e0.poll;
   assign rsp_found = r.e0.found;
   assign rsp_index = r.e0.idx;
   assign attention = r.attention;

endmodule // sio_host

`default_nettype wire

// >>> sio_pkg.sv
// serial peripheral bus: shared constants, op codes and timing counts
// assumes a single 250 MHz system clock in both ends of the link
`default_nettype none

package sio_pkg;

   // =========================================================
   // timing
   localparam int SYS_CLK_MHZ    = 250;
   localparam int BIT_PERIOD_NS  = 200;   // one bit pair per period
   localparam int PULSE_WIDTH_NS = 100;   // clock high time
   localparam int RESET_NS       = 1000;  // bus reset pulse length
   localparam int BIT_PERIOD_CYC = BIT_PERIOD_NS * SYS_CLK_MHZ / 1000;
   localparam int PULSE_HIGH_CYC = PULSE_WIDTH_NS * SYS_CLK_MHZ / 1000;
   localparam int RESET_CYC      = (RESET_NS * SYS_CLK_MHZ + 999) / 1000;

   // =========================================================
   // operation codes, first pair as {line a, line b}
   typedef enum logic [1:0] {
      OP_STORE_WORD = 2'b00,
      OP_STORE_BYTE = 2'b01,
      OP_LOAD_WORD  = 2'b10,
      OP_LOAD_BYTE  = 2'b11
   } sio_op_t;

   // =========================================================
   // frame layout, in clock pulses
   localparam logic [3:0] HEAD_PULSES  = 4'h5;  // op code plus address
   localparam logic [3:0] TURN_PULSE   = 4'h6;  // load turnaround pulse
   localparam logic [3:0] FIRST_RX     = 4'h7;  // first sampled pulse
   localparam logic [3:0] STORE_BYTE_N = 4'h9;
   localparam logic [3:0] STORE_WORD_N = 4'hd;
   localparam logic [3:0] LOAD_BYTE_N  = 4'ha;
   localparam logic [3:0] LOAD_WORD_N  = 4'he;
   localparam logic [3:0] POLL_NIBBLE  = 4'hf;  // poll address, top bits

   // pulses in a whole frame for a given op code
   function automatic logic [3:0] frame_pulses(input logic [1:0] op);
      unique case (sio_op_t'(op))
         OP_STORE_WORD: frame_pulses = STORE_WORD_N;
         OP_STORE_BYTE: frame_pulses = STORE_BYTE_N;
         OP_LOAD_WORD:  frame_pulses = LOAD_WORD_N;
         OP_LOAD_BYTE:  frame_pulses = LOAD_BYTE_N;
      endcase
   endfunction

   function automatic logic is_load(input logic [1:0] op);
      is_load = op[1];
   endfunction

   function automatic logic is_word(input logic [1:0] op);
      is_word = ~op[0];
   endfunction

endpackage

`default_nettype wire

// >>> sio_if.sv
// serial peripheral bus wires between processor end and peripheral end
// assumes undriven data lines read low; drops combine as wired-or
`timescale 1ns/10ps
`default_nettype none

interface sio_if;
   // processor side drive
   logic host_a_o;
   logic host_a_oe;
   logic host_b_o;
   logic host_b_oe;
   logic serial_bit_clock;
   logic serial_bus_reset;
   // peripheral side drive
   logic dev_a_o;
   logic dev_a_oe;
   logic dev_b_o;
   logic dev_b_oe;
   logic serial_attention_request;
   // resolved shared data lines
   logic serial_line_a;
   logic serial_line_b;

   // =========================================================
   // wired-or resolution, a released line reads low
   assign serial_line_a = (host_a_oe & host_a_o) | (dev_a_oe & dev_a_o);
   assign serial_line_b = (host_b_oe & host_b_o) | (dev_b_oe & dev_b_o);

   modport host (
      output host_a_o, host_a_oe, host_b_o, host_b_oe,
      output serial_bit_clock, serial_bus_reset,
      input  serial_line_a, serial_line_b, serial_attention_request
   );

   modport periph (
      output dev_a_o, dev_a_oe, dev_b_o, dev_b_oe,
      output serial_attention_request,
      input  serial_line_a, serial_line_b,
      input  serial_bit_clock, serial_bus_reset
   );
endinterface

`default_nettype wire

// >>> sio_periph.sv
// peripheral end: decodes its address, takes stores, answers loads/polls
// assumes bus clock, reset and data lines come from another domain
`timescale 1ns/10ps
`default_nettype none

module sio_periph #(
   parameter logic [7:0] MY_ADDR  = 8'h01,
   parameter int         POLL_BIT = 0
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // bus
   sio_if.periph            bus,
   // user side
   output logic             store_valid,
   output logic             store_word,
   output logic [15:0]      store_data,
   input  wire logic [15:0] load_data,
   output logic             load_taken,
   input  wire logic        irq_level
);
   localparam logic [15:0] POLL_MASK = 16'(1) << POLL_BIT;

   typedef struct packed {
      logic [1:0]  ck, rs, la, lb;   // synchronisers
      logic        ck_d;             // previous synced clock
      logic [3:0]  cnt;              // trailing edges in this frame
      logic [9:0]  hdr;
      logic [1:0]  op;
      logic        sel, match, poll;
      logic [15:0] txd;
      logic [7:0]  rxa, rxb;
      logic        oe, a_o, b_o, att;
      logic        st_v, st_w;
      logic [15:0] st_d;
      logic        ld_t;
   } periph_reg_t;

   periph_reg_t r, n;
   logic        rise, fall;
   logic [7:0]  addr;
   logic [9:0]  hdr_n;

   // =========================================================
   // edge finding and frame decode
   always_comb begin
      n = r;
      n.ck = {r.ck[0], bus.serial_bit_clock};
      n.rs = {r.rs[0], bus.serial_bus_reset};
      n.la = {r.la[0], bus.serial_line_a};
      n.lb = {r.lb[0], bus.serial_line_b};
      n.ck_d = r.ck[1];
      n.att = irq_level;
      n.st_v = 1'b0;
      n.ld_t = 1'b0;
      rise = r.ck[1] & ~r.ck_d;
      fall = ~r.ck[1] & r.ck_d;
      hdr_n = {r.hdr[7:0], r.la[1], r.lb[1]};
      // pairs arrive a7/a3 .. a4/a0 after the op code
      addr = {hdr_n[7], hdr_n[5], hdr_n[3], hdr_n[1],
              hdr_n[6], hdr_n[4], hdr_n[2], hdr_n[0]};
      if (r.rs[1]) begin
         n.cnt = '0;
         n.sel = 1'b0;
         n.oe  = 1'b0;
      end else if (fall) begin
         n.cnt = r.cnt + 4'h1;
         if (r.cnt < sio_pkg::HEAD_PULSES) begin
            n.hdr = hdr_n;
            if (r.cnt == sio_pkg::HEAD_PULSES - 4'h1) begin
               n.op = hdr_n[9:8];
               n.match = (addr == MY_ADDR);
               n.poll = (hdr_n[9:8] == sio_pkg::OP_LOAD_WORD) &&
                        (addr[7:4] == sio_pkg::POLL_NIBBLE);
               n.sel = n.match | (n.poll & irq_level);
            end
         end else if (r.sel && !sio_pkg::is_load(r.op)) begin
            n.rxa = {r.rxa[6:0], r.la[1]};
            n.rxb = {r.rxb[6:0], r.lb[1]};
         end
         if (r.sel && sio_pkg::is_load(r.op) &&
             r.cnt >= sio_pkg::TURN_PULSE) begin
            n.txd = {r.txd[13:0], 2'b00};
            n.a_o = r.txd[13];
            n.b_o = r.txd[12];
         end
         // last pulse ends the frame for everyone
         if (r.cnt >= sio_pkg::HEAD_PULSES &&
             r.cnt == sio_pkg::frame_pulses(r.op) - 4'h1) begin
            n.cnt = '0;
            n.sel = 1'b0;
            n.oe  = 1'b0;
            if (r.sel && !sio_pkg::is_load(r.op)) begin
               n.st_v = 1'b1;
               n.st_w = sio_pkg::is_word(r.op);
               n.st_d = sio_pkg::is_word(r.op) ?
                        {n.rxb, n.rxa} : {8'h00, n.rxa[3:0], n.rxb[3:0]};
            end
         end
      end else if (rise && r.cnt == sio_pkg::HEAD_PULSES &&
                   r.sel && sio_pkg::is_load(r.op)) begin
         // sixth pulse: take the line, first pair out
         n.txd = r.poll ? POLL_MASK :
                 (sio_pkg::is_word(r.op) ? load_data
                                         : {load_data[7:0], 8'h00});
         n.oe  = 1'b1;
         n.a_o = n.txd[15];
         n.b_o = n.txd[14];
         n.ld_t = ~r.poll;
      end
   end

   // =========================================================
   // single state register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign bus.dev_a_o = r.a_o;
   assign bus.dev_b_o = r.b_o;
   assign bus.dev_a_oe = r.oe;
   assign bus.dev_b_oe = r.oe;
   assign bus.serial_attention_request = r.att;
   assign store_valid = r.st_v;
   assign store_word = r.st_w;
   assign store_data = r.st_d;
   assign load_taken = r.ld_t;

endmodule // sio_periph

`default_nettype wire

// >>> sio_bus_assertions.sv
// checker: timing and drive rules on the shared serial bus wires
// assumes one system clock; inputs are the interface's own signals
`timescale 1ns/10ps
`default_nettype none
module sio_bus_assertions #(
   parameter int RESET_CYCLES = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // bus wires
   input wire logic host_a_o,
   input wire logic host_a_oe,
   input wire logic host_b_oe,
   input wire logic serial_bit_clock,
   input wire logic serial_bus_reset,
   input wire logic dev_a_oe,
   input wire logic dev_b_oe
);
   // =========================================================
   // run lengths of clock high, bus reset and peripheral drive
   logic [9:0] hi_cnt;
   logic [9:0] rst_cnt;
   logic [9:0] dev_cnt;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hi_cnt  <= 10'h000;
         rst_cnt <= 10'h000;
         dev_cnt <= 10'h000;
      end else begin
         hi_cnt  <= serial_bit_clock ? hi_cnt + 10'h001 : 10'h000;
         rst_cnt <= serial_bus_reset ? rst_cnt + 10'h001 : 10'h000;
         dev_cnt <= dev_a_oe ? dev_cnt + 10'h001 : 10'h000;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // =========================================================
   // properties
   property p_clock_still;
      serial_bus_reset |-> !serial_bit_clock;
   endproperty
   a_clock_still: assert property (p_clock_still)
      else $error("bus clock runs during bus reset");
   // an aborted pulse is cut short, so bus reset excuses it
   property p_pulse_width;
      $fell(serial_bit_clock) && !serial_bus_reset |-> hi_cnt == 10'd25;
   endproperty
   a_pulse_width: assert property (p_pulse_width)
      else $error("bus clock high time wrong");
   property p_low_phase;
      $fell(serial_bit_clock) |-> !serial_bit_clock [*8];
   endproperty
   a_low_phase: assert property (p_low_phase)
      else $error("bus clock low time too short");
   property p_no_fight;
      !(host_a_oe && dev_a_oe) && !(host_b_oe && dev_b_oe);
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("both ends drive a data line");
   property p_dev_start;
      $rose(dev_a_oe) |-> serial_bit_clock && !host_a_oe;
   endproperty
   a_dev_start: assert property (p_dev_start)
      else $error("peripheral drive starts off a pulse");
   property p_dev_stop;
      $fell(dev_a_oe) && !serial_bus_reset |-> !serial_bit_clock;
   endproperty
   a_dev_stop: assert property (p_dev_stop)
      else $error("peripheral release off a trailing edge");
   property p_dev_bound;
      dev_cnt <= 10'd430;
   endproperty
   a_dev_bound: assert property (p_dev_bound)
      else $error("peripheral drives too long");
   property p_data_on_rise;
      host_a_oe && $past(host_a_oe) && $changed(host_a_o)
         |-> $rose(serial_bit_clock);
   endproperty
   a_data_on_rise: assert property (p_data_on_rise)
      else $error("host data moved off a clock rise");
   property p_reset_len;
      $fell(serial_bus_reset)
         |-> rst_cnt >= RESET_CYCLES && rst_cnt <= RESET_CYCLES + 2;
   endproperty
   a_reset_len: assert property (p_reset_len)
      else $error("bus reset length wrong");
   property p_reset_release;
      serial_bus_reset [*4] |-> !dev_a_oe && !dev_b_oe && !host_a_oe;
   endproperty
   a_reset_release: assert property (p_reset_release)
      else $error("data line driven in bus reset");
   // main scenarios reached
   c_load: cover property ($rose(dev_a_oe));
   c_reset_end: cover property ($fell(serial_bus_reset));
   c_pulse: cover property ($fell(serial_bit_clock));
endmodule // sio_bus_assertions
`default_nettype wire

// >>> serial_peripheral_bus_master_tb.sv
// testbench: processor end and one peripheral end on one bus
// assumes package, interface, both ends and checker compile first
`timescale 1ns/10ps
`default_nettype none
module serial_peripheral_bus_master_tb;
   localparam logic [7:0] MY_ADDR = 8'h5a;
   localparam int RST_CYC = 4;
   // =========================================================
   // stimulus, observation and bookkeeping
   logic sys_clk, nrst, cmd_valid, cmd_ready, cmd_poll, rsp_valid;
   logic rsp_ready, rsp_poll, rsp_found, reset_request, attention;
   logic store_valid, store_word, load_taken, irq_level, st_word;
   logic [1:0] cmd_op;
   logic [3:0] rsp_index;
   logic [7:0] cmd_addr;
   logic [15:0] cmd_data, rsp_data, store_data, load_data, st_data;
   logic [1:0] pairs[$];
   int st_seen, ld_seen, fail_count, compares;
   sio_if u_sio_if ();
   sio_host #(.RESET_CYCLES(RST_CYC)) u_sio_host (
      .sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_poll(cmd_poll),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_poll(rsp_poll),
      .rsp_found(rsp_found), .rsp_index(rsp_index),
      .reset_request(reset_request), .attention(attention),
      .bus(u_sio_if));
   sio_periph #(.MY_ADDR(MY_ADDR), .POLL_BIT(3)) u_sio_periph (
      .sys_clk(sys_clk), .nrst(nrst), .bus(u_sio_if),
      .store_valid(store_valid), .store_word(store_word),
      .store_data(store_data), .load_data(load_data),
      .load_taken(load_taken), .irq_level(irq_level));
   sio_bus_assertions #(.RESET_CYCLES(RST_CYC)) u_sio_bus_assertions (
      .sys_clk(sys_clk), .nrst(nrst), .host_a_o(u_sio_if.host_a_o),
      .host_a_oe(u_sio_if.host_a_oe), .host_b_oe(u_sio_if.host_b_oe),
      .serial_bit_clock(u_sio_if.serial_bit_clock),
      .serial_bus_reset(u_sio_if.serial_bus_reset),
      .dev_a_oe(u_sio_if.dev_a_oe), .dev_b_oe(u_sio_if.dev_b_oe));
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // wire pairs as they stand at each trailing bus clock edge
   always @(negedge u_sio_if.serial_bit_clock) begin
      if (nrst === 1'b1)
         pairs.push_back({u_sio_if.serial_line_a, u_sio_if.serial_line_b});
   end
   // user side pulses of the peripheral last one cycle only
   always @(posedge sys_clk) begin
      if (store_valid === 1'b1) begin
         st_seen++;
         st_data = store_data;
         st_word = store_word;
      end
      if (load_taken === 1'b1)
         ld_seen++;
   end
   // =========================================================
   // shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h", $time, what, got);
      end
   endtask
   task automatic send(input logic [1:0] op, input logic poll,
                       input logic [7:0] addr);
      pairs.delete();
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_poll = poll;
      cmd_addr = addr;
      cmd_data = 16'ha5c3 ^ {addr, addr};
      for (int i = 0; i < 2000; i++) begin
         @(posedge sys_clk);
         if (cmd_ready === 1'b1) break;
      end
      chk({15'h0, cmd_ready}, 16'h0001, "command taken");
      #1;
      cmd_valid = 1'b0;
   endtask
   // frame length and every pair but a load's turnaround pair, worked out from op, address and data
   task automatic check_wire(input logic [1:0] op, input logic poll,
                             input logic [7:0] a, input logic [15:0] d);
      int n, j;
      logic [1:0] e;
      n = op == 2'b01 ? 9 : op == 2'b00 ? 13 : op == 2'b11 ? 10 : 14;
      for (int i = 0; i < 1000 && pairs.size() < n; i++)
         @(posedge sys_clk);
      repeat (30) @(posedge sys_clk);
      chk(16'(pairs.size()), 16'(n), "pulses");
      for (int i = 0; i < n && i < pairs.size(); i++) begin
         j = op[1] ? i - 6 : i - 5;
         if (i == 0) e = op;
         else if (i < 5) e = {poll | a[8-i], a[4-i]};
         else if (!op[1]) e = op[0] ? {d[7-j], d[3-j]} : {d[7-j], d[15-j]};
         else if (i > 5 && op[0]) e = {d[7-2*j], d[6-2*j]};
         else if (i > 5) e = {d[15-2*j], d[14-2*j]};
         if (i != 5 || !op[1]) chk(16'(pairs[i]), 16'(e), "pair");
      end
   endtask
   task automatic get_rsp(output logic [15:0] d, output logic [5:0] f);
      for (int i = 0; i < 1000; i++) begin
         @(posedge sys_clk);
         if (rsp_valid === 1'b1) break;
      end
      #1;
      d = rsp_valid === 1'b1 ? rsp_data : 16'hxxxx;
      f = {rsp_poll, rsp_found, rsp_index};
      rsp_ready = 1'b1;
      @(posedge sys_clk);
      #1;
      rsp_ready = 1'b0;
   endtask
   // =========================================================
   // scenarios
   task automatic test_store();
      st_seen = 0;
      send(2'b01, 1'b0, MY_ADDR);
      check_wire(2'b01, 1'b0, MY_ADDR, cmd_data);
      chk({8'h00, st_data[7:0]}, 16'h0099, "byte");
      chk({15'h0, st_word}, 16'h0000, "byte kind");
      send(2'b00, 1'b0, MY_ADDR);
      check_wire(2'b00, 1'b0, MY_ADDR, cmd_data);
      chk(st_data, 16'hff99, "word");
      chk({13'h0, st_word, 2'(st_seen)}, 16'h0006, "stores");
      $display("store test done");
   endtask
   task automatic test_load();
      logic [15:0] d;
      logic [5:0] f;
      logic hit;
      ld_seen = 0;
      load_data = 16'h7eb4;
      send(2'b11, 1'b0, MY_ADDR);
      check_wire(2'b11, 1'b0, MY_ADDR, 16'h7eb4);
      load_data = 16'hd21e;
      send(2'b10, 1'b0, MY_ADDR);
      check_wire(2'b10, 1'b0, MY_ADDR, 16'hd21e);
      // both answers held back: a third command must be refused
      #1;
      cmd_valid = 1'b1;
      hit = 1'b0;
      repeat (600) @(posedge sys_clk) hit |= cmd_ready;
      #1;
      cmd_valid = 1'b0;
      chk({15'h0, hit}, 16'h0000, "full buffer took");
      get_rsp(d, f);
      chk(d, 16'h00b4, "byte load");
      chk({15'h0, f[5]}, 16'h0000, "poll flag");
      get_rsp(d, f);
      chk(d, 16'hd21e, "word load");
      chk(16'(ld_seen), 16'h0002, "loads taken");
      $display("load test done");
   endtask
   task automatic test_unselected();
      logic [15:0] d;
      logic [5:0] f;
      st_seen = 0;
      ld_seen = 0;
      send(2'b00, 1'b0, MY_ADDR ^ 8'h01);
      check_wire(2'b00, 1'b0, MY_ADDR ^ 8'h01, cmd_data);
      send(2'b11, 1'b0, MY_ADDR ^ 8'h80);
      check_wire(2'b11, 1'b0, MY_ADDR ^ 8'h80, 16'h0000);
      get_rsp(d, f);
      chk(d, 16'h0000, "idle lines");
      chk(16'(st_seen + ld_seen), 16'h0000, "wrong drop");
      $display("address test done");
   endtask
   task automatic test_poll();
      logic [15:0] d;
      logic [5:0] f;
      irq_level = 1'b1;
      repeat (8) @(posedge sys_clk);
      chk({15'h0, attention}, 16'h0001, "attention");
      send(2'b10, 1'b1, 8'h00);
      check_wire(2'b10, 1'b1, 8'h00, 16'h0008);
      get_rsp(d, f);
      chk(d, 16'h0008, "poll word");
      chk({10'h0, f}, 16'h0033, "poll index");
      irq_level = 1'b0;
      send(2'b10, 1'b1, 8'h00);
      check_wire(2'b10, 1'b1, 8'h00, 16'h0000);
      get_rsp(d, f);
      chk({10'h0, f[5:4], 3'h0, ld_seen[0]}, 16'h0020, "no poll");
      $display("poll test done");
   endtask
   task automatic test_bus_reset();
      send(2'b10, 1'b0, MY_ADDR);
      repeat (140) @(posedge sys_clk);
      #1;
      reset_request = 1'b1;
      @(posedge sys_clk);
      #1;
      reset_request = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk({15'h0, u_sio_if.serial_bus_reset}, 16'h0001, "bus reset");
      st_seen = 0;
      send(2'b01, 1'b0, MY_ADDR);
      check_wire(2'b01, 1'b0, MY_ADDR, cmd_data);
      chk({rsp_valid, 15'(st_seen)}, 16'h0001, "after reset");
      $display("bus reset test done");
   endtask
   // =========================================================
   // run and verdict
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      {fail_count, compares, st_seen, ld_seen} = '0;
      {cmd_valid, cmd_poll, rsp_ready, reset_request, irq_level} = '0;
      {cmd_op, cmd_addr, cmd_data, load_data} = '0;
      nrst = 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      test_store();
      test_load();
      test_unselected();
      test_poll();
      test_bus_reset();
      print_verdict();
   end
   // watchdog: the tests need about 6200 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule // serial_peripheral_bus_master_tb
`default_nettype wire
